/* design/asr_ctrl.sv */
`default_nettype none
// Behaviour
// - Write enable stays high through every read access.
// - Address settles before or with chip select falling.
// - Address valid 8 ns before write end, write cycle at least 10 ns.
// - Select low 8 ns before write end, write pulse at least 8 ns.
// - Write data valid 6 ns before write end, hold 0 ns.
// - Write pulse exceeds bus release plus data overlap when output enabled.
// - Controller never drives the bus while memory outputs are active.
// - Deselect before lowering supply; wait one read cycle after restore.
module asr_ctrl (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire logic [asr_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [asr_pkg::DATA_W-1:0] req_wdata,
  output logic                            req_ready,
  output logic                            rd_valid,
  output logic [asr_pkg::DATA_W-1:0]      rd_data,
  input  wire logic                       retain_req,
  output logic                            retain_ack,
  output logic [asr_pkg::ADDR_W-1:0]      word_select_lines,
  output logic                            chip_sel_n,
  output logic                            out_en_n,
  output logic                            wr_en_n,
  output logic [asr_pkg::DATA_W-1:0]      byte_bus_o,
  output logic                            byte_bus_oe,
  input  wire logic [asr_pkg::DATA_W-1:0] byte_bus_i
);
  asr_pins_if pins ();

  asr_pin_drv u_drv (
    .clk               (clk),
    .reset             (reset),
    .pins              (pins),
    .word_select_lines (word_select_lines),
    .chip_sel_n        (chip_sel_n),
    .out_en_n          (out_en_n),
    .wr_en_n           (wr_en_n),
    .byte_bus_o        (byte_bus_o),
    .byte_bus_oe       (byte_bus_oe),
    .byte_bus_i        (byte_bus_i)
  );

  asr_pkg::asr_state_e               state_reg;
  logic [asr_pkg::CNT_W-1:0]         cnt_reg;
  logic [asr_pkg::ADDR_W-1:0]        addr_reg;
  logic [asr_pkg::DATA_W-1:0]        wdata_reg;
  logic                              cs_n_reg;
  logic                              oe_n_reg;
  logic                              we_n_reg;
  logic                              dq_oe_reg;
  logic                              cnt_done;

  assign cnt_done = (cnt_reg == asr_pkg::CNT_ZERO);

  // Pin copies are registered once more in the driver, so the pin timing
  // seen by the memory is this state delayed by one clock.
  assign pins.word_select_lines = addr_reg;
  assign pins.chip_sel_n        = cs_n_reg;
  assign pins.out_en_n          = oe_n_reg;
  assign pins.wr_en_n           = we_n_reg;
  assign pins.byte_bus_out      = wdata_reg;
  assign pins.byte_bus_oe       = dq_oe_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= asr_pkg::ASR_IDLE;
      cnt_reg   <= asr_pkg::CNT_ZERO;
    end else begin
      unique case (state_reg)
        asr_pkg::ASR_IDLE: begin
          if (retain_req) begin
            state_reg <= asr_pkg::ASR_SLEEP;
          end else if (req_valid && req_write) begin
            state_reg <= asr_pkg::ASR_WR;
            cnt_reg   <= asr_pkg::CNT_W'(asr_pkg::WP_CYC - 1);
          end else if (req_valid) begin
            state_reg <= asr_pkg::ASR_RD;
            // Three pipeline stages separate pin drive from sampled data.
            cnt_reg   <= asr_pkg::CNT_W'(asr_pkg::RD_CYC + 2);
          end
        end
        asr_pkg::ASR_RD: begin
          if (cnt_done) begin
            state_reg <= asr_pkg::ASR_RD_GAP;
            cnt_reg   <= asr_pkg::CNT_W'(asr_pkg::REL_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        asr_pkg::ASR_RD_GAP, asr_pkg::ASR_WR_GAP, asr_pkg::ASR_WAKE: begin
          if (cnt_done) begin
            state_reg <= asr_pkg::ASR_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        asr_pkg::ASR_WR: begin
          if (cnt_done) begin
            state_reg <= asr_pkg::ASR_WR_GAP;
            cnt_reg   <= asr_pkg::CNT_W'(asr_pkg::WC_CYC);
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        asr_pkg::ASR_SLEEP: begin
          if (!retain_req) begin
            state_reg <= asr_pkg::ASR_WAKE;
            cnt_reg   <= asr_pkg::CNT_W'(asr_pkg::RECOVER_CYC);
          end
        end
        default: begin
          state_reg <= asr_pkg::ASR_IDLE;
        end
      endcase
    end
  end

  // Address and data are latched at acceptance and held through each access.
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else if (state_reg == asr_pkg::ASR_IDLE && req_valid && !retain_req) begin
      addr_reg  <= req_addr;
      wdata_reg <= req_wdata;
    end
  end

  // Strobes: select falls together with the address, write enable falls
  // with select, so the memory never turns its outputs on during a write.
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      we_n_reg  <= 1'b1;
      dq_oe_reg <= 1'b0;
    end else begin
      cs_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      we_n_reg  <= 1'b1;
      dq_oe_reg <= 1'b0;
      if (state_reg == asr_pkg::ASR_IDLE && req_valid && !retain_req) begin
        cs_n_reg  <= 1'b0;
        oe_n_reg  <= req_write;
        we_n_reg  <= !req_write;
        dq_oe_reg <= req_write;
      end else if (state_reg == asr_pkg::ASR_RD && !cnt_done) begin
        cs_n_reg <= 1'b0;
        oe_n_reg <= 1'b0;
      end else if (state_reg == asr_pkg::ASR_WR && !cnt_done) begin
        cs_n_reg  <= 1'b0;
        we_n_reg  <= 1'b0;
        dq_oe_reg <= 1'b1;
      end else if (state_reg == asr_pkg::ASR_WR && cnt_done) begin
        dq_oe_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (state_reg == asr_pkg::ASR_RD && cnt_done) begin
        rd_valid <= 1'b1;
        rd_data  <= pins.byte_bus_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      req_ready  <= 1'b0;
      retain_ack <= 1'b0;
    end else begin
      req_ready  <= (state_reg == asr_pkg::ASR_IDLE) && !req_valid && !retain_req;
      retain_ack <= (state_reg == asr_pkg::ASR_SLEEP);
    end
  end
endmodule
`default_nettype wire

/* design/asr_pin_drv.sv */
`default_nettype none
// Registers every pin so the top's outputs come straight from flip-flops, and
// passes the incoming byte bus through two flip-flops before use.
module asr_pin_drv (
  input  wire logic                       clk,
  input  wire logic                       reset,
  asr_pins_if.drv                         pins,
  output logic [asr_pkg::ADDR_W-1:0]      word_select_lines,
  output logic                            chip_sel_n,
  output logic                            out_en_n,
  output logic                            wr_en_n,
  output logic [asr_pkg::DATA_W-1:0]      byte_bus_o,
  output logic                            byte_bus_oe,
  input  wire logic [asr_pkg::DATA_W-1:0] byte_bus_i
);
  logic [asr_pkg::DATA_W-1:0] sync1_reg;
  logic [asr_pkg::DATA_W-1:0] sync2_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      word_select_lines <= '0;
      chip_sel_n        <= 1'b1;
      out_en_n          <= 1'b1;
      wr_en_n           <= 1'b1;
      byte_bus_o        <= '0;
      byte_bus_oe       <= 1'b0;
    end else begin
      word_select_lines <= pins.word_select_lines;
      chip_sel_n        <= pins.chip_sel_n;
      out_en_n          <= pins.out_en_n;
      wr_en_n           <= pins.wr_en_n;
      byte_bus_o        <= pins.byte_bus_out;
      byte_bus_oe       <= pins.byte_bus_oe;
    end
  end

  always_ff @(posedge clk) begin
    sync1_reg <= byte_bus_i;
    sync2_reg <= sync1_reg;
  end
  assign pins.byte_bus_in = sync2_reg;
endmodule
`default_nettype wire

/* design/asr_pins_if.sv */
`default_nettype none
interface asr_pins_if;
  logic [asr_pkg::ADDR_W-1:0] word_select_lines;
  logic                       chip_sel_n;
  logic                       out_en_n;
  logic                       wr_en_n;
  logic [asr_pkg::DATA_W-1:0] byte_bus_out;
  logic                       byte_bus_oe;
  logic [asr_pkg::DATA_W-1:0] byte_bus_in;
  modport ctrl (output word_select_lines, chip_sel_n, out_en_n, wr_en_n, byte_bus_out,
                byte_bus_oe, input byte_bus_in);
  modport drv (input word_select_lines, chip_sel_n, out_en_n, wr_en_n, byte_bus_out,
               byte_bus_oe, output byte_bus_in);
endinterface
`default_nettype wire

/* design/asr_pkg.sv */
`default_nettype none
package asr_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 10000;
  // Device timing in picoseconds, as printed in nanoseconds.
  localparam int T_READ_CYCLE_PS = 10000;
  localparam int T_ADDR_ACCESS_PS = 10000;
  localparam int T_OE_ACCESS_PS = 4500;
  localparam int T_BUS_RELEASE_PS = 4000;
  localparam int T_STORE_TO_BUS_RELEASE_PS = 4000;
  localparam int T_WRITE_CYCLE_PS = 10000;
  localparam int T_WRITE_PULSE_PS = 8000;
  localparam int T_DATA_OVERLAP_PS = 6000;
  localparam int T_RECOVERY_PS = 10000;
  function automatic int cycles_up(input int ps);
    int n;
    n = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction
  // Read waits for the slower of address access and output enable access.
  localparam int RD_CYC = cycles_up(T_ADDR_ACCESS_PS) + 1;
  localparam int RC_CYC = cycles_up(T_READ_CYCLE_PS);
  localparam int REL_CYC = cycles_up(T_BUS_RELEASE_PS);
  // Write pulse exceeds release plus data overlap, so it also covers 8 ns.
  localparam int WP_CYC = cycles_up(T_STORE_TO_BUS_RELEASE_PS + T_DATA_OVERLAP_PS) + 1;
  localparam int WC_CYC = cycles_up(T_WRITE_CYCLE_PS);
  localparam int RECOVER_CYC = cycles_up(T_RECOVERY_PS);
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  typedef enum logic [2:0] {
    ASR_IDLE, ASR_RD, ASR_RD_GAP, ASR_WR, ASR_WR_GAP, ASR_SLEEP, ASR_WAKE
  } asr_state_e;
endpackage
`default_nettype wire

/* test/asr_ctrl_chk.sv */
`default_nettype none
module asr_ctrl_chk (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       rd_valid,
  input wire logic                       retain_ack,
  input wire logic [asr_pkg::ADDR_W-1:0] word_select_lines,
  input wire logic                       chip_sel_n,
  input wire logic                       out_en_n,
  input wire logic                       wr_en_n,
  input wire logic [asr_pkg::DATA_W-1:0] byte_bus_o,
  input wire logic                       byte_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_read_exclusive: assert property (!out_en_n |-> wr_en_n && !byte_bus_oe)
    else $error("read strobes overlap a write or bus drive");
  a_read_window: assert property ($fell(out_en_n) |-> (!chip_sel_n && !out_en_n)[*5] ##1 out_en_n)
    else $error("read strobe window wrong length");
  a_read_answer: assert property ($fell(out_en_n) |-> ##4 rd_valid)
    else $error("read data not returned on time");
  a_rd_one_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
  a_read_addr_held: assert property (!out_en_n && !$past(out_en_n) |-> $stable(word_select_lines))
    else $error("address moved during read");
  a_write_pulse: assert property ($fell(wr_en_n) |-> (!wr_en_n && !chip_sel_n && byte_bus_oe)[*2]
    ##1 (wr_en_n && chip_sel_n && byte_bus_oe))
    else $error("write pulse shape wrong");
  a_write_stable: assert property (!$past(wr_en_n) |-> $stable(word_select_lines)
    && $stable(byte_bus_o))
    else $error("address or data moved during write");
  a_retain_desel: assert property (retain_ack |-> chip_sel_n && wr_en_n)
    else $error("memory selected while retained");
  c_read: cover property ($fell(out_en_n));
  c_write: cover property ($fell(wr_en_n));
  c_retain: cover property ($rose(retain_ack));
endmodule
bind asr_ctrl asr_ctrl_chk asr_ctrl_chk_inst (.clk(clk), .reset(reset), .rd_valid(rd_valid),
  .retain_ack(retain_ack), .word_select_lines(word_select_lines), .chip_sel_n(chip_sel_n),
  .out_en_n(out_en_n), .wr_en_n(wr_en_n), .byte_bus_o(byte_bus_o), .byte_bus_oe(byte_bus_oe));
`default_nettype wire

/* test/asr_mem_model.sv */
`default_nettype none
module asr_mem_model (
  input  wire logic [asr_pkg::ADDR_W-1:0] word_select_lines,
  input  wire logic                       chip_sel_n,
  input  wire logic                       out_en_n,
  input  wire logic                       wr_en_n,
  input  wire logic [asr_pkg::DATA_W-1:0] byte_bus_o,
  input  wire logic                       byte_bus_oe,
  output logic      [asr_pkg::DATA_W-1:0] byte_bus_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [asr_pkg::DATA_W-1:0] mem [logic [asr_pkg::ADDR_W-1:0]];
  logic [asr_pkg::DATA_W-1:0] last;
  logic                       held_off;
  logic                       drive;
  logic                       wr_on;
  always @(negedge chip_sel_n) held_off = !wr_en_n;
  always @(posedge chip_sel_n) held_off = 1'b0;
  assign drive = !chip_sel_n && !out_en_n && wr_en_n && !held_off;
  // Unwritten bytes read as zero, not as the X that a missing entry of this logic array would return.
  always @(*) if (drive && !$isunknown(word_select_lines)) begin
    last = mem.exists(word_select_lines) ? mem[word_select_lines] : 8'h00;
  end
  // A released bus shows the inverse of the last byte, so a stale sample cannot match.
  assign #2 byte_bus_i = drive ? last : ~last;
  assign wr_on = !chip_sel_n && !wr_en_n;
  always @(negedge wr_on) if (!$isunknown(word_select_lines)) begin
    mem[word_select_lines] = byte_bus_oe ? byte_bus_o : ~byte_bus_o;
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, req_valid, req_write, retain_req, req_ready, rd_valid, retain_ack;
  logic chip_sel_n, out_en_n, wr_en_n, byte_bus_oe;
  logic [asr_pkg::ADDR_W-1:0] req_addr, word_select_lines;
  logic [asr_pkg::DATA_W-1:0] req_wdata, rd_data, byte_bus_o, byte_bus_i;
  logic [asr_pkg::DATA_W-1:0] shadow [logic [asr_pkg::ADDR_W-1:0]];
  logic [asr_pkg::ADDR_W-1:0] addrs [$];
  logic [31:0]                r;
  int                         n_mismatch, check_count, seed, wait_n;
  asr_ctrl asr_ctrl_inst (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .retain_req(retain_req), .retain_ack(retain_ack),
    .word_select_lines(word_select_lines), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .wr_en_n(wr_en_n), .byte_bus_o(byte_bus_o), .byte_bus_oe(byte_bus_oe),
    .byte_bus_i(byte_bus_i));
  asr_mem_model asr_mem_model_inst (.word_select_lines(word_select_lines),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
    .byte_bus_o(byte_bus_o), .byte_bus_oe(byte_bus_oe), .byte_bus_i(byte_bus_i));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Called just after a clock edge. Ready only rises while no request is pending, so the
  // request is raised once the block is idle and held for exactly the edge that takes it.
  task automatic xfer(input logic w, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("request ready", 8'h01, {7'h00, req_ready});
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_addr = $random(seed);
    req_wdata = $random(seed);
    if (w) shadow[a] = d;
    else read_back(a);
  endtask
  task automatic read_back(input logic [18:0] a);
    int n;
    n = 0;
    while (rd_valid !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("read valid", 8'h01, {7'h00, rd_valid});
    check("read byte", shadow[a], rd_data);
  endtask
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
  initial begin
    seed = 32'h0000_a6f0;
    {req_valid, req_write, retain_req, req_addr, req_wdata} = '0;
    n_mismatch = 0;
    check_count = 0;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    xfer(1'b1, 19'h0_0000, 8'ha5);
    xfer(1'b1, 19'h7_ffff, 8'h5a);
    xfer(1'b0, 19'h0_0000, 8'h00);
    repeat (24) begin
      r = $random(seed);
      addrs.push_back(r[18:0]);
      xfer(1'b1, r[18:0], r[26:19]);
    end
    foreach (addrs[i]) xfer(1'b0, addrs[i], 8'h00);
    // Back-to-back overwrite of one byte, then an immediate read.
    xfer(1'b1, addrs[0], 8'h3c);
    xfer(1'b1, addrs[0], 8'hc3);
    xfer(1'b0, addrs[0], 8'h00);
    // A read held pending through retention must wait until the wake-up.
    retain_req = 1'b1;
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr = 19'h7_ffff;
    repeat (6) @(posedge clk);
    #1;
    check("retain ack", 8'h01, {7'h00, retain_ack});
    check("deselected", 8'h01, {7'h00, chip_sel_n});
    retain_req = 1'b0;
    wait_n = 0;
    while (chip_sel_n !== 1'b0 && wait_n < 20) begin
      @(posedge clk);
      #1;
      wait_n++;
    end
    // The held read is taken at the first idle edge after wake-up; drop it once it starts.
    req_valid = 1'b0;
    read_back(19'h7_ffff);
    test_done;
  end
endmodule
`default_nettype wire
